// >>> src/cpu_execution_state_timing.sv
// How it works
// RQ1: Instruction states equal sum of each cycle count times its state cost.
// RQ2: Instruction fetch from on-chip memory costs 2 states per cycle.
// RQ3: Byte data access to on-chip RAM costs 2 states per cycle.
// RQ4: Branch address read from on-chip memory costs 2 states per cycle.
// RQ5: Stack operation in on-chip RAM costs 2 states per cycle.
// RQ6: Byte access to a peripheral costs 2 or 3 states, chosen per module.
// RQ7: Counts come from opcode and mode lookup; instruction held until total elapses.
`default_nettype none
module cpu_execution_state_timing
   import exec_timing_pkg::*;
(
   input  wire logic               clk_i,
   input  wire logic               rst_n_i,
   input  wire logic               ce_i,
   input  wire logic               start_i,
   input  wire instr_req_t         req_i,
   output logic                    busy_o,
   output logic                    done_o,
   output logic [TOT_W-1:0]        states_o
);

   // ----------------------------------------
   // Lookup memory
   // ----------------------------------------
   logic [ENTRY_W-1:0] rom_data;
   cycle_count_rom u_rom (
      .clk_i  (clk_i),
      .ce_i   (ce_i),
      .addr_i ({req_i.opcode, req_i.mode}),
      .data_o (rom_data)
   );

   // ----------------------------------------
   // Weighted sum
   // ----------------------------------------
   cycle_counts_t      cnt;
   logic [COST_W-1:0]  byte_cost;
   logic [COST_W-1:0]  word_cost;
   logic [TOT_W-1:0]   weighted;
   instr_req_t         held;

   always_comb begin
      cnt       = cycle_counts_t'(rom_data);
      byte_cost = held.data_periph ? (held.periph_slow ? S_BYTE_SLOW : S_BYTE_FAST) //RQ6
                                   : S_BYTE_MEM; //RQ3
      word_cost = held.data_periph ? S_WORD_PERIPH : S_WORD_MEM;
      weighted  = TOT_W'(cnt.fetch    * S_FETCH_MEM)  //RQ2
                + TOT_W'(cnt.branch   * S_BRANCH_MEM) //RQ4
                + TOT_W'(cnt.stack    * S_STACK_MEM)  //RQ5
                + TOT_W'(cnt.byte_acc * byte_cost)
                + TOT_W'(cnt.word_acc * word_cost)
                + TOT_W'(cnt.internal * S_INTERNAL);  //RQ1
   end

   // ----------------------------------------
   // Control
   // ----------------------------------------
   exec_state_t        state;
   exec_state_t        next_state;
   logic [TOT_W-1:0]   remain;
   logic [TOT_W-1:0]   next_remain;
   instr_req_t         next_held;
   logic               next_busy;
   logic               next_done;
   logic [TOT_W-1:0]   next_states;

   always_comb begin
      next_state  = state;
      next_remain = remain;
      next_held   = held;
      next_busy   = busy_o;
      next_done   = 1'b0;
      next_states = states_o;
      case (state)
         ST_IDLE: begin
            if (start_i) begin
               next_held  = req_i;
               next_busy  = 1'b1;
               next_state = ST_LOOKUP; //RQ7
            end
         end
         ST_LOOKUP: begin
            next_state = ST_SUM;
         end
         ST_SUM: begin
            next_states = weighted;
            next_remain = (weighted > TOT_ONE) ? weighted - TOT_ONE : '0;
            next_state  = ST_RUN;
         end
         ST_RUN: begin
            if (remain == '0) begin
               next_busy  = 1'b0;
               next_done  = 1'b1;
               next_state = ST_IDLE;
            end else begin
               next_remain = remain - TOT_ONE; //RQ7
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state    <= ST_IDLE;
         remain   <= '0;
         held     <= '0;
         busy_o   <= 1'b0;
         done_o   <= 1'b0;
         states_o <= '0;
      end else if (ce_i) begin
         state    <= next_state;
         remain   <= next_remain;
         held     <= next_held;
         busy_o   <= next_busy;
         done_o   <= next_done;
         states_o <= next_states;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   logic [TOT_W-1:0] run_cnt;
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         run_cnt <= '0;
      end else if (ce_i) begin
         run_cnt <= (state == ST_SUM) ? '0 : (busy_o ? run_cnt + TOT_ONE : '0);
      end
   end

   a_total_weighted: assert property (@(posedge clk_i) disable iff (!rst_n_i) //RQ1
      (ce_i && state == ST_SUM) |=> states_o == $past(weighted))
      else $error("state total not latched");

   a_fetch_cost: assert property (@(posedge clk_i) disable iff (!rst_n_i) //RQ2
      (state == ST_SUM && rom_data == ENTRY_W'({4'h1, 20'h0})) |-> weighted == 8'h02)
      else $error("fetch cost wrong");

   a_byte_ram: assert property (@(posedge clk_i) disable iff (!rst_n_i) //RQ3
      (state == ST_SUM && !held.data_periph && rom_data == ENTRY_W'({4'h2, 8'h0, 4'h2, 8'h0}))
      |-> weighted == 8'h08)
      else $error("ram byte cost wrong");

   a_branch_stack: assert property (@(posedge clk_i) disable iff (!rst_n_i) //RQ4
      (state == ST_SUM && rom_data == ENTRY_W'({4'h2, 4'h1, 4'h1, 12'h0})) |-> weighted == 8'h08)
      else $error("branch or stack cost wrong");

   a_stack_cost: assert property (@(posedge clk_i) disable iff (!rst_n_i) //RQ5
      (ce_i && state == ST_SUM && rom_data == ENTRY_W'({4'h2, 4'h1, 4'h1, 12'h0}))
      |=> states_o == 8'h08)
      else $error("stack cost wrong");

   a_periph_cost: assert property (@(posedge clk_i) disable iff (!rst_n_i) //RQ6
      (state == ST_SUM && held.data_periph && rom_data == ENTRY_W'({4'h2, 8'h0, 4'h2, 8'h0}))
      |-> weighted == (held.periph_slow ? 8'h0A : 8'h08))
      else $error("peripheral byte cost wrong");

   sequence s_start;
      ce_i && state == ST_IDLE && start_i;
   endsequence

   a_start_busy: assert property (@(posedge clk_i) disable iff (!rst_n_i) //RQ7
      s_start |=> busy_o && !done_o)
      else $error("busy not raised");

   a_hold_length: assert property (@(posedge clk_i) disable iff (!rst_n_i) //RQ7
      (ce_i && done_o) |-> run_cnt == states_o || states_o == '0)
      else $error("hold length mismatch");

   a_fetch_two: assert property (@(posedge clk_i) disable iff (!rst_n_i) //RQ2
      (state == ST_SUM && rom_data == ENTRY_W'({4'h2, 20'h0})) |-> weighted == 8'h04)
      else $error("two fetch cost wrong");

   a_internal_cost: assert property (@(posedge clk_i) disable iff (!rst_n_i) //RQ1
      (state == ST_SUM && rom_data == ENTRY_W'({4'h2, 16'h0, 4'h2})) |-> weighted == 8'h06)
      else $error("internal cost wrong");

   a_remain_load: assert property (@(posedge clk_i) disable iff (!rst_n_i) //RQ7
      (ce_i && state == ST_SUM && weighted == 8'h08) |=> remain == 8'h07)
      else $error("remaining count not loaded");

   // ----------------------------------------
   // Freeze and handshake checks
   // ----------------------------------------
   sequence s_frozen;
      !ce_i;
   endsequence

   sequence s_finish;
      ce_i && state == ST_RUN && remain == '0;
   endsequence

   a_freeze_state: assert property (@(posedge clk_i) disable iff (!rst_n_i) //RQ7
      s_frozen |=> state == $past(state))
      else $error("state moved while frozen");

   a_freeze_remain: assert property (@(posedge clk_i) disable iff (!rst_n_i) //RQ7
      s_frozen |=> remain == $past(remain))
      else $error("count moved while frozen");

   a_freeze_outputs: assert property (@(posedge clk_i) disable iff (!rst_n_i) //RQ7
      s_frozen |=> busy_o == $past(busy_o) && done_o == $past(done_o))
      else $error("handshake moved while frozen");

   a_freeze_total: assert property (@(posedge clk_i) disable iff (!rst_n_i) //RQ1
      s_frozen |=> $stable(states_o))
      else $error("total moved while frozen");

   a_done_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i) //RQ7
      (ce_i && done_o) |=> !done_o)
      else $error("done longer than one cycle");

   a_done_ends_busy: assert property (@(posedge clk_i) disable iff (!rst_n_i) //RQ7
      s_finish |=> done_o && !busy_o)
      else $error("done or busy wrong at end");

   a_busy_until_done: assert property (@(posedge clk_i) disable iff (!rst_n_i) //RQ7
      (ce_i && state == ST_RUN && remain != '0) |=> busy_o && !done_o)
      else $error("instruction released early");

   a_states_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i) //RQ1
      (ce_i && state == ST_RUN) |=> $stable(states_o))
      else $error("total changed while running");

   a_idle_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i) //RQ7
      (ce_i && state == ST_IDLE && !start_i) |=> !busy_o)
      else $error("busy without request");

   a_lookup_sum: assert property (@(posedge clk_i) disable iff (!rst_n_i) //RQ7
      (ce_i && state == ST_LOOKUP) |=> state == ST_SUM)
      else $error("lookup not followed by sum");

   a_held_stable: assert property (@(posedge clk_i) disable iff (!rst_n_i) //RQ7
      (ce_i && busy_o) |=> $stable(held))
      else $error("held request changed while busy");

endmodule
`default_nettype wire

// >>> src/exec_timing_pkg.sv
package exec_timing_pkg;

   // ----------------------------------------
   // Widths
   // ----------------------------------------
   localparam int OPC_W   = 8;
   localparam int MODE_W  = 2;
   localparam int IDX_W   = OPC_W + MODE_W;
   localparam int CNT_W   = 4;
   localparam int COST_W  = 2;
   localparam int TOT_W   = 8;
   localparam int NTYPES  = 6;
   localparam int ENTRY_W = NTYPES * CNT_W;

   // ----------------------------------------
   // Per-cycle state costs
   // ----------------------------------------
   localparam logic [COST_W-1:0] S_FETCH_MEM  = 2'h2;
   localparam logic [COST_W-1:0] S_BRANCH_MEM = 2'h2;
   localparam logic [COST_W-1:0] S_STACK_MEM  = 2'h2;
   localparam logic [COST_W-1:0] S_BYTE_MEM   = 2'h2;
   localparam logic [COST_W-1:0] S_WORD_MEM   = 2'h2;
   localparam logic [COST_W-1:0] S_BYTE_FAST  = 2'h2;
   localparam logic [COST_W-1:0] S_BYTE_SLOW  = 2'h3;
   localparam logic [COST_W-1:0] S_WORD_PERIPH = 2'h2;
   localparam logic [COST_W-1:0] S_INTERNAL   = 2'h1;
   localparam logic [TOT_W-1:0]  TOT_ONE      = 8'h01;

   // ----------------------------------------
   // Addressing modes
   // ----------------------------------------
   localparam logic [MODE_W-1:0] MODE_REG  = 2'h0;
   localparam logic [MODE_W-1:0] MODE_IND  = 2'h1;
   localparam logic [MODE_W-1:0] MODE_ABS8 = 2'h2;
   localparam logic [MODE_W-1:0] MODE_IMM  = 2'h3;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic [CNT_W-1:0] fetch;
      logic [CNT_W-1:0] branch;
      logic [CNT_W-1:0] stack;
      logic [CNT_W-1:0] byte_acc;
      logic [CNT_W-1:0] word_acc;
      logic [CNT_W-1:0] internal;
   } cycle_counts_t;

   typedef struct packed {
      logic [OPC_W-1:0]  opcode;
      logic [MODE_W-1:0] mode;
      logic              data_periph;
      logic              periph_slow;
   } instr_req_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_LOOKUP,
      ST_SUM,
      ST_RUN
   } exec_state_t;

endpackage

// >>> src/cycle_count_rom.sv
`default_nettype none
module cycle_count_rom
   import exec_timing_pkg::*;
(
   input  wire logic                clk_i,
   input  wire logic                ce_i,
   input  wire logic [IDX_W-1:0]    addr_i,
   output var  logic [ENTRY_W-1:0]  data_o
);

   // ----------------------------------------
   // Table contents
   // ----------------------------------------
   logic [ENTRY_W-1:0] mem [0:(1<<IDX_W)-1];
   logic [ENTRY_W-1:0] next_data;

   initial begin
      for (int i = 0; i < (1 << IDX_W); i++) begin
         mem[i] = {4'h1, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
      end
      mem[{8'h80, MODE_IMM}]  = {4'h1, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
      mem[{8'h79, MODE_IMM}]  = {4'h2, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
      mem[{8'h7A, MODE_IMM}]  = {4'h3, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
      mem[{8'h76, MODE_IND}]  = {4'h2, 4'h0, 4'h0, 4'h1, 4'h0, 4'h0};
      mem[{8'h76, MODE_ABS8}] = {4'h2, 4'h0, 4'h0, 4'h1, 4'h0, 4'h0};
      mem[{8'h72, MODE_IND}]  = {4'h2, 4'h0, 4'h0, 4'h2, 4'h0, 4'h0};
      mem[{8'h40, MODE_REG}]  = {4'h2, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
      mem[{8'h58, MODE_REG}]  = {4'h2, 4'h0, 4'h0, 4'h0, 4'h0, 4'h2};
      mem[{8'h5E, MODE_REG}]  = {4'h2, 4'h1, 4'h1, 4'h0, 4'h0, 4'h0};
   end

   always_comb begin
      next_data = data_o;
      if (ce_i) begin
         next_data = mem[addr_i];
      end
   end

   always_ff @(posedge clk_i) begin
      data_o <= next_data;
   end

endmodule
`default_nettype wire

// >>> testbench/periph_map_model.sv
`default_nettype none
module periph_map_model (
   input  wire logic [3:0] sel_i,
   output logic            data_periph_o,
   output logic            periph_slow_o
);
   // ----------------------------------------
   // Access location
   // ----------------------------------------
   // Location 0 is on-chip RAM, every other location is a peripheral module
   assign data_periph_o = (sel_i != 4'h0);
   // Odd locations are the slow peripheral modules
   assign periph_slow_o = sel_i[0];
endmodule
`default_nettype wire

// >>> testbench/cpu_execution_state_timing_tb.sv
`default_nettype none
module cpu_execution_state_timing_tb import exec_timing_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic             clk_i;
   logic             rst_n_i;
   logic             ce_i;
   logic             start_i;
   instr_req_t       req_i;
   logic             busy_o;
   logic             done_o;
   logic [TOT_W-1:0] states_o;
   logic [7:0]       opc;
   logic [1:0]       md;
   logic [3:0]       sel;
   logic             dp;
   logic             ps;
   int               fail_count;
   int               tests_run;
   // Known entries, counts packed as fetch, branch, stack, byte, internal
   logic [7:0]  op_tab [10] = '{8'h80, 8'h79, 8'h7A, 8'h76, 8'h76, 8'h72, 8'h40, 8'h58,
                                8'h5E, 8'hFF};
   logic [1:0]  md_tab [10] = '{MODE_IMM, MODE_IMM, MODE_IMM, MODE_IND, MODE_ABS8, MODE_IND,
                                MODE_REG, MODE_REG, MODE_REG, MODE_IND};
   logic [19:0] cnt_tab [10] = '{20'h10000, 20'h20000, 20'h30000, 20'h20010, 20'h20010,
                                 20'h20020, 20'h20000, 20'h20002, 20'h21100, 20'h10000};
   assign req_i = '{opcode: opc, mode: md, data_periph: dp, periph_slow: ps};
   // ----------------------------------------
   // Instances
   // ----------------------------------------
   periph_map_model pm_u (
      .sel_i         (sel),
      .data_periph_o (dp),
      .periph_slow_o (ps)
   );
   cpu_execution_state_timing dut_u (
      .clk_i    (clk_i),
      .rst_n_i  (rst_n_i),
      .ce_i     (ce_i),
      .start_i  (start_i),
      .req_i    (req_i),
      .busy_o   (busy_o),
      .done_o   (done_o),
      .states_o (states_o)
   );
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [7:0] expected(logic [19:0] c, logic p, logic s);
      logic [7:0] byte_cost;
      byte_cost = p ? (s ? 8'h03 : 8'h02) : 8'h02;
      return 8'(c[19:16]) * 8'h02 + 8'(c[15:12]) * 8'h02 + 8'(c[11:8]) * 8'h02
             + 8'(c[7:4]) * byte_cost + 8'(c[3:0]);
   endfunction
   task automatic check(string name, logic [15:0] exp, logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic run_one(int i, logic [3:0] s, int stall);
      int         k;
      logic [7:0] exp;
      @(posedge clk_i);
      opc     <= op_tab[i];
      md      <= md_tab[i];
      sel     <= s;
      start_i <= 1'b1;
      @(posedge clk_i);
      start_i <= 1'b0;
      k = 0;
      do begin
         @(posedge clk_i);
         ce_i <= !(k >= 1 && k < 1 + stall);
         #1;
         k++;
      end while (done_o !== 1'b1 && k < 300);
      if (k >= 300) begin
         fail_count++;
         $display("MISMATCH done_o expected 1 seen %b", done_o);
         conclude();
      end else begin
         exp = expected(cnt_tab[i], dp, ps);
         check("states_o", 16'(exp), 16'(states_o));
         check("cycles", 16'(exp) + 16'h0002 + 16'(stall), 16'(k));
         check("busy_o", 16'h0000, 16'(busy_o));
      end
   endtask
   // ----------------------------------------
   // Stimulus
   // ----------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   initial begin
      fail_count = 0;
      tests_run  = 0;
      rst_n_i    = 1'b0;
      ce_i       = 1'b1;
      start_i    = 1'b0;
      opc        = 8'h00;
      md         = 2'h0;
      sel        = 4'h0;
      void'($urandom(73));
      repeat (6) @(posedge clk_i);
      rst_n_i <= 1'b1;
      #1;
      check("reset", 16'h0000, {6'h00, busy_o, done_o, states_o});
      // Every entry at RAM, fast peripheral and slow peripheral, one with a freeze
      for (int i = 0; i < 10; i++) begin
         run_one(i, 4'h0, 0);
         run_one(i, 4'h2, 0);
         run_one(i, 4'h3, 3);
      end
      repeat (40) begin
         run_one(int'($urandom % 10), 4'($urandom), int'($urandom % 8));
      end
      // Reset in the middle of an instruction, then a clean one
      @(posedge clk_i);
      opc     <= op_tab[5];
      md      <= md_tab[5];
      sel     <= 4'h3;
      start_i <= 1'b1;
      @(posedge clk_i);
      start_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      #1;
      check("mid reset", 16'h0000, {6'h00, busy_o, done_o, states_o});
      run_one(5, 4'h3, 0);
      conclude();
   end
endmodule
`default_nettype wire
